// [rtl/dcd_top.sv]
// converter channel digital front end: apb registers, sample fifo, trigger and dma logic
// Contract
// - power enable drives only the analog part; registers keep working regardless
// - control bit 1 set turns the output buffer off, clear turns it on
// - control bit 2 enables trigger loading; clear loads held data at once
// - control bits 5:3 select timer, external line or software trigger
// - untriggered: a written sample reaches the output one cycle after the write
// - triggered: load three cycles after pin trigger, one after software trigger
// - output register is never written by the bus, only by a load
// - control bit 12 enables dma requests on triggered loads (bit 2 set), clear blocks them
// - control bit 13 enables the underrun interrupt
// - software sets manual trigger bit; hardware clears it once loaded
// - offset 0x08 bits 11:0 take a right aligned 12-bit sample
// - offset 0x0C bits 15:4 take a left aligned sample; 3:0 reserved
// - offsets 0x10 and 0x28 bits 7:0 take an 8-bit sample
// - offset 0x14 is decoded as second channel 12-bit holding register
// - offset 0x2C reads current output value in bits 11:0, writes ignored
// - status bit 13 underrun set by hardware, cleared by writing one
`timescale 1ns/1ps

// two flip-flop synchroniser for pin inputs
module dcd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      dout   <= '0;
    end else if (clk_en) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : dcd_sync

// sample fifo with valid and ready on both sides
module dcd_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0]      count_r, count_nxt;
  logic             push, pop;

  assign in_ready  = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count next values, pointers wrap at depth
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (clk_en) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // storage, written only on push
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule : dcd_fifo

// top: apb slave, holding registers, trigger select, output register
module dcd_top import dcd_pkg::*; (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [4:0]        timer_trigger_out,
  input  wire logic              ext_line_trigger,
  input  wire logic              dma_ack,
  output logic                   dma_req,
  output logic                   irq,
  output logic                   channel_power_enable,
  output logic                   out_buffer_off,
  output logic      [SAMPLE_W-1:0] dac_value
);
  logic [CTRL_W-1:0]   ctrl_r, ctrl_nxt;
  logic                sw_r, sw_nxt;
  logic [SAMPLE_W-1:0] hold_r, hold_nxt, hold2_r, hold2_nxt, out_r, out_nxt;
  logic                flag_r, flag_nxt, dma_req_r, dma_req_nxt, irq_r, irq_nxt;
  dcd_acc_st_t         st_r, st_nxt;
  logic [DATA_W-1:0]   prdata_r, prdata_nxt, rd_mux;
  logic                pslverr_r, pslverr_nxt;
  logic [TRG_W-1:0]    trg_sync, trg_prev_r, trg_rise;
  logic                a_ctrl, a_sw, a_h12r, a_h12l, a_h8r, a_h12r2, a_h8rp, a_out, a_sts;
  logic                mapped, hold_wr, accept, stall, wr_fire;
  logic [SAMPLE_W-1:0] sample_in, fifo_data;
  logic                fifo_in_ready, fifo_valid, trig_en, trig_hit, load_fire, dma_ev;
  dcd_trig_sel_t       sel;

  // outputs straight from flip-flops, pready decoded from the access state
  assign prdata               = prdata_r;
  assign pready               = (st_r == ST_ANSWER);
  assign pslverr              = pslverr_r;
  assign dac_value            = out_r;
  assign dma_req              = dma_req_r;
  assign irq                  = irq_r;
  assign channel_power_enable = ctrl_r[CTRL_PWR_BIT];
  assign out_buffer_off       = ctrl_r[CTRL_BUFOFF_BIT];

  // address decode, word aligned only
  assign a_ctrl  = (paddr == OFS_CTRL);
  assign a_sw    = (paddr == OFS_SWTRIG);
  assign a_h12r  = (paddr == OFS_H12R);
  assign a_h12l  = (paddr == OFS_H12L);
  assign a_h8r   = (paddr == OFS_H8R);
  assign a_h12r2 = (paddr == OFS_H12R2);
  assign a_h8rp  = (paddr == OFS_H8RP);
  assign a_out   = (paddr == OFS_OUT);
  assign a_sts   = (paddr == OFS_STS);
  assign mapped  = a_ctrl | a_sw | a_h12r | a_h12l | a_h8r | a_h12r2 | a_h8rp | a_out | a_sts;
  assign hold_wr = pwrite & (a_h12r | a_h12l | a_h8r | a_h8rp);
  // a full fifo holds pready low on sample writes
  assign stall   = hold_wr & ~fifo_in_ready;
  assign accept  = (st_r == ST_IDLE) & psel & penable & ~stall;
  assign wr_fire = (st_r == ST_ANSWER) & psel & penable & pwrite;

  // sample alignment into the common 12-bit form
  always_comb begin
    sample_in = pwdata[SAMPLE_W-1:0];
    if (a_h12l) begin
      sample_in = pwdata[15:4];
    end else if (a_h8r || a_h8rp) begin
      sample_in = {pwdata[7:0], 4'h0};
    end else begin
      sample_in = pwdata[SAMPLE_W-1:0];
    end
  end

  // read data mux, reserved bits zero
  always_comb begin
    rd_mux = '0;
    case (1'b1)
      a_ctrl:          rd_mux = {18'h0, ctrl_r};
      a_sw:            rd_mux = {31'h0, sw_r};
      a_h12r:          rd_mux = {20'h0, hold_r};
      a_h12l:          rd_mux = {16'h0, hold_r, 4'h0};
      a_h8r, a_h8rp:   rd_mux = {24'h0, hold_r[11:4]};
      a_h12r2:         rd_mux = {20'h0, hold2_r};
      a_out:           rd_mux = {20'h0, out_r};
      a_sts:           rd_mux = {18'h0, flag_r, 13'h0};
      default:         rd_mux = '0;
    endcase
  end

  // bus access state: one wait cycle, then pready for one cycle
  always_comb begin
    st_nxt      = st_r;
    prdata_nxt  = '0;
    pslverr_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (accept) begin
          st_nxt      = ST_ANSWER;
          prdata_nxt  = pwrite ? '0 : rd_mux;
          pslverr_nxt = ~mapped;
        end
      end
      ST_ANSWER: st_nxt = ST_IDLE;
      default:   st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r      <= ST_IDLE;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      st_r      <= st_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // pin triggers: timers in bits 4:0, external line in bit 5
  dcd_sync #(.WIDTH(TRG_W)) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .din    ({ext_line_trigger, timer_trigger_out}),
    .dout   (trg_sync)
  );
  assign trg_rise = trg_sync & ~trg_prev_r;

  dcd_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_valid  (wr_fire & hold_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (sample_in),
    .out_valid (fifo_valid),
    .out_ready (load_fire),
    .out_data  (fifo_data)
  );

  // trigger selection and load decision
  assign trig_en = ctrl_r[CTRL_TRGEN_BIT];
  assign sel     = dcd_trig_sel_t'(ctrl_r[CTRL_SEL_MSB:CTRL_SEL_LSB]);
  always_comb begin
    trig_hit = 1'b0;
    case (sel)
      SEL_TMR6:  trig_hit = trg_rise[0];
      SEL_TMR3:  trig_hit = trg_rise[1];
      SEL_TMR7:  trig_hit = trg_rise[2];
      SEL_TMR15: trig_hit = trg_rise[3];
      SEL_TMR2:  trig_hit = trg_rise[4];
      SEL_EXT:   trig_hit = trg_rise[5];
      SEL_SW:    trig_hit = sw_r;
      default:   trig_hit = 1'b0;
    endcase
    load_fire = trig_en ? trig_hit : fifo_valid;
  end
  assign dma_ev = load_fire & trig_en & ctrl_r[CTRL_DMAEN_BIT];

  // control, samples, output, software trigger, dma and underrun next values
  always_comb begin
    ctrl_nxt    = ctrl_r;
    hold_nxt    = hold_r;
    hold2_nxt   = hold2_r;
    out_nxt     = out_r;
    sw_nxt      = sw_r;
    dma_req_nxt = dma_req_r;
    flag_nxt    = flag_r;
    if (wr_fire && a_ctrl) begin
      ctrl_nxt = pwdata[CTRL_W-1:0] & CTRL_WR_MASK;
    end
    if (wr_fire && hold_wr) begin
      hold_nxt = sample_in;
    end
    if (wr_fire && a_h12r2) begin
      hold2_nxt = pwdata[SAMPLE_W-1:0];
    end
    // output changes only on a load
    if (load_fire) begin
      out_nxt = fifo_valid ? fifo_data : hold_r;
    end
    // hardware clear after load, a write wins
    if (load_fire && trig_en && sel == SEL_SW) begin
      sw_nxt = 1'b0;
    end
    if (wr_fire && a_sw) begin
      sw_nxt = pwdata[SW_BIT];
    end
    if (dma_ack) begin
      dma_req_nxt = 1'b0;
    end
    // request per trigger, stale request dropped
    if (dma_ev) begin
      dma_req_nxt = ~(dma_req_r & ~dma_ack);
    end
    if (!ctrl_r[CTRL_DMAEN_BIT]) begin
      dma_req_nxt = 1'b0;
    end
    // write one clears, hardware set wins
    if (wr_fire && a_sts && pwdata[STS_UDR_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (dma_ev && dma_req_r && !dma_ack) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = flag_r & ctrl_r[CTRL_UDRIE_BIT];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r     <= CTRL_RST;
      hold_r     <= SAMPLE_RST;
      hold2_r    <= SAMPLE_RST;
      out_r      <= SAMPLE_RST;
      sw_r       <= 1'b0;
      dma_req_r  <= 1'b0;
      flag_r     <= 1'b0;
      irq_r      <= 1'b0;
      trg_prev_r <= '0;
    end else if (clk_en) begin
      ctrl_r     <= ctrl_nxt;
      hold_r     <= hold_nxt;
      hold2_r    <= hold2_nxt;
      out_r      <= out_nxt;
      sw_r       <= sw_nxt;
      dma_req_r  <= dma_req_nxt;
      flag_r     <= flag_nxt;
      irq_r      <= irq_nxt;
      trg_prev_r <= trg_sync;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !clk_en);

  sequence s_ctrl_wr;
    wr_fire && a_ctrl;
  endsequence

  sequence s_ext_edge;
    $rose(ext_line_trigger) && trig_en && sel == SEL_EXT && !wr_fire;
  endsequence

  sequence s_sw_start;
    wr_fire && a_sw && pwdata[SW_BIT] && trig_en && sel == SEL_SW && !a_ctrl;
  endsequence

  property p_buffer_ctrl;
    s_ctrl_wr |=> out_buffer_off == $past(pwdata[CTRL_BUFOFF_BIT]) ##0
      channel_power_enable == $past(pwdata[CTRL_PWR_BIT]);
  endproperty
  a_buffer_ctrl: assert property (p_buffer_ctrl) else $error("buffer bit not taken");

  property p_direct_load;
    (wr_fire && a_h12r && !trig_en && !fifo_valid) |-> ##2 out_r == $past(pwdata[11:0], 2);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load late");

  property p_pin_load;
    s_ext_edge ##1 (trig_en && sel == SEL_EXT)[*1] |-> ##1 load_fire;
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("pin trigger load late");

  property p_sw_load;
    s_sw_start |=> load_fire ##1 !sw_r;
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("software trigger not served");

  property p_out_only_load;
    !load_fire |=> $stable(out_r);
  endproperty
  a_out_only_load: assert property (p_out_only_load) else $error("output changed");

  property p_dma_gate;
    $rose(dma_req_r) |-> $past(ctrl_r[CTRL_DMAEN_BIT]) && $past(load_fire);
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma request without enable");

  property p_irq_gate;
    !ctrl_r[CTRL_UDRIE_BIT] |=> !irq_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

  property p_irq_on;
    (flag_r && ctrl_r[CTRL_UDRIE_BIT]) |=> irq_r;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_underrun;
    (dma_ev && dma_req_r && !dma_ack) |=> flag_r && !dma_req_r;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_w1c;
    (wr_fire && a_sts && !pwdata[STS_UDR_BIT] && flag_r) |=> flag_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("zero write cleared flag");

  property p_left_read;
    (accept && !pwrite && a_h12l) |=> prdata_r == {16'h0, $past(hold_r), 4'h0};
  endproperty
  a_left_read: assert property (p_left_read) else $error("left aligned readback wrong");

  property p_ch2_hold;
    (wr_fire && a_h12r2) |=> hold2_r == $past(pwdata[11:0]);
  endproperty
  a_ch2_hold: assert property (p_ch2_hold) else $error("second channel hold wrong");

  property p_out_read;
    (accept && !pwrite && a_out) |=> prdata_r == {20'h0, $past(out_r)};
  endproperty
  a_out_read: assert property (p_out_read) else $error("output readback wrong");

endmodule : dcd_top

// [shared/dcd_pkg.sv]
// constants, offsets and types for the converter channel digital front end
package dcd_pkg;

  // bus and sample geometry
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned SAMPLE_W   = 12;
  localparam int unsigned CTRL_W     = 14;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned TRG_W      = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SWTRIG = 8'h04;
  localparam logic [7:0] OFS_H12R   = 8'h08;
  localparam logic [7:0] OFS_H12L   = 8'h0C;
  localparam logic [7:0] OFS_H8R    = 8'h10;
  localparam logic [7:0] OFS_H12R2  = 8'h14;
  localparam logic [7:0] OFS_H8RP   = 8'h28;
  localparam logic [7:0] OFS_OUT    = 8'h2C;
  localparam logic [7:0] OFS_STS    = 8'h34;

  // control field positions
  localparam int unsigned CTRL_PWR_BIT    = 0;
  localparam int unsigned CTRL_BUFOFF_BIT = 1;
  localparam int unsigned CTRL_TRGEN_BIT  = 2;
  localparam int unsigned CTRL_SEL_LSB    = 3;
  localparam int unsigned CTRL_SEL_MSB    = 5;
  localparam int unsigned CTRL_DMAEN_BIT  = 12;
  localparam int unsigned CTRL_UDRIE_BIT  = 13;
  localparam logic [13:0] CTRL_WR_MASK    = 14'h303F;
  localparam int unsigned SW_BIT          = 0;
  localparam int unsigned STS_UDR_BIT     = 13;

  // values after reset
  localparam logic [13:0] CTRL_RST   = 14'h0000;
  localparam logic [11:0] SAMPLE_RST = 12'h000;

  // load latency in clock cycles after each trigger kind
  localparam int unsigned TRIG_PIN_CYCLES = 3;
  localparam int unsigned TRIG_SW_CYCLES  = 1;

  // trigger source codes
  typedef enum logic [2:0] {
    SEL_TMR6  = 3'h0,
    SEL_TMR3  = 3'h1,
    SEL_TMR7  = 3'h2,
    SEL_TMR15 = 3'h3,
    SEL_TMR2  = 3'h4,
    SEL_RSVD  = 3'h5,
    SEL_EXT   = 3'h6,
    SEL_SW    = 3'h7
  } dcd_trig_sel_t;

  // bus access states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h1,
    ST_ANSWER = 2'h2
  } dcd_acc_st_t;

endpackage : dcd_pkg

// [test/dac_channel_digital_interface_tb.sv]
// self-checking bench for the converter channel front end
`timescale 1ns/1ps
module dac_channel_digital_interface_tb import dcd_pkg::*; ;
  localparam logic [7:0] RST_OFS [7] = '{OFS_CTRL, OFS_H12R, OFS_H12L, OFS_H8R,
                                         OFS_H8RP, OFS_OUT, OFS_STS};
  logic                clock;
  logic                resetn;
  logic                clk_en;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic [5:0]          pins;
  logic [5:0]          pin;
  logic                dma_ack;
  logic                dma_req;
  logic                irq;
  logic                pwr_en;
  logic                buf_off;
  logic                stall;
  logic                done;
  logic                re;
  logic [31:0]         rv;
  logic [SAMPLE_W-1:0] dac_value;
  logic [SAMPLE_W-1:0] cur;
  int                  num_errors;
  int                  samples_checked;

  dcd_top dut (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trigger_out(pins[4:0]), .ext_line_trigger(pins[5]),
    .dma_ack(dma_ack), .dma_req(dma_req), .irq(irq), .channel_power_enable(pwr_en),
    .out_buffer_off(buf_off), .dac_value(dac_value)
  );

  dcd_dma_model dma_partner (
    .clock(clock), .resetn(resetn), .dma_req(dma_req), .stall(stall), .dma_ack(dma_ack)
  );

  // free running clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one apb transfer, held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: no bus answer", $time);
      wrap_up();
    end
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    cmp(re, 0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 0);
    cmp(rv, exp);
    cmp(re, 0);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // output holds one more cycle, then shows the new value
  task step(input logic [11:0] nv);
    #1;
    cmp(dac_value, cur);
    cyc(1);
    cmp(dac_value, nv);
    cur = nv;
  endtask : step

  // pin edge: old value after two edges, new after the third
  task pulse(input logic [5:0] p, input logic [11:0] nv);
    @(posedge clock);
    pins <= p;
    cyc(2);
    cmp(dac_value, cur);
    cyc(1);
    cmp(dac_value, nv);
    cur = nv;
    @(posedge clock);
    pins <= 6'h00;
    repeat (2) @(posedge clock);
  endtask : pulse

  task swl(input logic [11:0] s);
    wr(OFS_H12R, {20'h0, s});
    wr(OFS_SWTRIG, 32'h1);
    step(s);
    cyc(1);
  endtask : swl

  // hang guard
  initial begin
    repeat (50000) @(posedge clock);
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pins = '0;
    stall = 1'b0;
    clk_en = 1'b1;
    done = 1'b0;
    cur = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(RST_OFS[i], 0);
    cmp({irq, dma_req, pwr_en, buf_off}, 0);
    wr(OFS_CTRL, 32'hFFFFFFFF);
    rd(OFS_CTRL, 32'h0000303F);
    cmp({pwr_en, buf_off}, 2'h3);
    wr(OFS_CTRL, 32'h0);
    cyc(0);
    cmp({pwr_en, buf_off}, 2'h0);
    wr(OFS_H12R, 32'hFFFFF5A5);
    step(12'h5A5);
    rd(OFS_H12R, 32'h5A5);
    wr(OFS_H12L, 32'h0000ABCF);
    step(12'hABC);
    rd(OFS_H12L, 32'hABC0);
    wr(OFS_H8R, 32'h1C3);
    step(12'hC30);
    rd(OFS_H8R, 32'hC3);
    wr(OFS_H8RP, 32'h5E);
    step(12'h5E0);
    wr(OFS_OUT, 32'h123);
    cyc(3);
    rd(OFS_OUT, 32'h5E0);
    wr(OFS_H12R2, 32'h9AB);
    rd(OFS_H12R2, 32'h9AB);
    xfer(1'b0, 8'h18, 0);
    cmp(rv, 0);
    cmp(re, 1);
    xfer(1'b1, 8'h3C, 32'hFFFF);
    cmp(re, 1);
    for (int k = 0; k < 7; k++) begin
      pin = (k == 6) ? 6'h20 : 6'h01 << k;
      wr(OFS_CTRL, 32'h4 | (32'(k) << 3));
      if (k == 5) begin
        pulse(6'h3F, cur);
      end else begin
        wr(OFS_H12R, 32'h100 + 32'(k));
        pulse(~pin, cur);
        pulse(pin, 12'h100 + 12'(k));
      end
    end
    wr(OFS_CTRL, 32'h3C);
    wr(OFS_H12R, 32'h3A5);
    cyc(3);
    cmp(dac_value, cur);
    wr(OFS_SWTRIG, 32'h1);
    step(12'h3A5);
    rd(OFS_SWTRIG, 0);
    wr(OFS_CTRL, 32'h4);
    for (int i = 1; i <= 8; i++) wr(OFS_H12R, 32'h800 + 32'(i));
    fork
      begin
        xfer(1'b1, OFS_H12R, 32'h809);
        done = 1'b1;
      end
      begin
        cyc(8);
        cmp(done, 0);
        pulse(6'h01, 12'h801);
      end
    join
    cmp(done, 1);
    for (int i = 2; i <= 9; i++) pulse(6'h01, 12'h800 + 12'(i));
    pulse(6'h01, 12'h809);
    wr(OFS_CTRL, 32'h303C);
    swl(12'h111);
    cmp(dma_req, 1);
    cyc(8);
    cmp(dma_req, 0);
    rd(OFS_STS, 0);
    stall <= 1'b1;
    swl(12'h222);
    cmp(dma_req, 1);
    swl(12'h333);
    cmp(dma_req, 0);
    rd(OFS_STS, 32'h2000);
    cmp(irq, 1);
    wr(OFS_STS, 32'h0);
    rd(OFS_STS, 32'h2000);
    wr(OFS_CTRL, 32'h103C);
    cyc(2);
    cmp(irq, 0);
    wr(OFS_CTRL, 32'h303C);
    cyc(2);
    cmp(irq, 1);
    wr(OFS_STS, 32'h2000);
    rd(OFS_STS, 0);
    cmp(irq, 0);
    stall <= 1'b0;
    wr(OFS_CTRL, 32'h3C);
    swl(12'h444);
    cyc(2);
    cmp(dma_req, 0);
    // clock enable low freezes the pending direct load
    wr(OFS_CTRL, 32'h0);
    wr(OFS_H12R, 32'h777);
    clk_en <= 1'b0;
    cyc(3);
    cmp(dac_value, cur);
    @(posedge clock);
    clk_en <= 1'b1;
    cyc(2);
    cmp(dac_value, 12'h777);
    cur = 12'h777;
    wrap_up();
  end
endmodule : dac_channel_digital_interface_tb

// [test/dcd_dma_model.sv]
// dma controller model that answers channel requests
`timescale 1ns/1ps
module dcd_dma_model #(
  parameter int unsigned DELAY = 2
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic dma_req,
  input  wire logic stall,
  output logic      dma_ack
);
  int unsigned cnt_r;

  // answer DELAY cycles after the request is first seen, never while stalled by the bench
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dma_ack <= 1'b0;
      cnt_r   <= 0;
    end else if (dma_req && !stall && !dma_ack) begin
      dma_ack <= (cnt_r == DELAY);
      cnt_r   <= (cnt_r == DELAY) ? 0 : cnt_r + 1;
    end else begin
      dma_ack <= 1'b0;
      cnt_r   <= 0;
    end
  end
endmodule : dcd_dma_model
